// File: hw/rca_core.sv
`timescale 1ns/1ps
// Contract
// RL1 - Fetch one 12-bit instruction per cycle over its own program bus.
// RL2 - Program fetch and data access use separate buses in one cycle.
// RL3 - Two stages: the next instruction is fetched while the current executes.
// RL4 - Every instruction takes one cycle except those that branch.
// RL5 - Program counter addresses an internal store of 512, 1K or 2K words.
// RL6 - Special registers, program counter too, sit in the data map, direct or indirect.
// RL7 - Eight-bit ALU adds, subtracts, shifts and does logic in two's complement.
// RL8 - Two operands: accumulator with file or literal; one operand: either. Literal logic ops pair the literal with a file register, not the accumulator.
// RL9 - Accumulator is eight bits wide and has no data address.
// RL10 - ALU updates carry, nibble carry and zero flags per instruction.
// RL11 - In subtraction carry and nibble carry mean no borrow out.
// RL12 - In RC mode the cycle clock pin runs at a quarter of the clock.
// RL13 - Master reset input held low resets the core.
// RL14 - A branch drops the prefetched instruction and costs one refill cycle.
module rca_core #(
   parameter int PC_W = rca_pkg::PC_W_DFLT
) (
   // Clock and resets
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic master_reset_n,
   // Oscillator option
   input wire logic rc_osc_mode,
   // Program store load port
   input wire logic load_en,
   input wire logic [PC_W-1:0] load_addr,
   input wire logic [rca_pkg::INSTR_W-1:0] load_data,
   // Core state
   output logic [PC_W-1:0] fetch_addr,
   output logic [rca_pkg::INSTR_W-1:0] exec_instr,
   output logic exec_valid,
   output logic [rca_pkg::DATA_W-1:0] acc_out,
   output logic [rca_pkg::DATA_W-1:0] status_out,
   output logic [rca_pkg::DATA_W-1:0] fsr_out,
   // Cycle clock pin
   output logic cycle_clock_out
);
   localparam int DW = rca_pkg::DATA_W;
   localparam int IW = rca_pkg::INSTR_W;
   localparam int AW = rca_pkg::RAM_AW;

   function automatic logic [AW-1:0] eff_addr(input logic [4:0] f, input logic [DW-1:0] fsr);
      eff_addr = (f == rca_pkg::A_INDF) ? fsr[AW-1:0] : f;
   endfunction

   logic rst;
   logic [PC_W-1:0] pc_q, pc_d, stk0_q, stk0_d, stk1_q, stk1_d, tgt;
   logic [IW-1:0] ir_q, ir_d, rom_data;
   logic ex_v_q, ex_v_d;
   logic [DW-1:0] w_q, w_d, status_q, status_d, fsr_q, fsr_d, st_base;
   logic [AW-1:0] fa_q, fa_d;
   logic fwd_q, fwd_d;
   logic [DW-1:0] fwd_data_q, ram_rdata, ram_val, file_val;
   logic [rca_pkg::CYC_CNT_W-1:0] cyc_q, cyc_d;
   logic cco_q, cco_d;
   logic [1:0] grp, lop;
   logic [3:0] bop;
   logic [2:0] bsel;
   logic dst_f, is_bit, is_ctl;
   logic [DW-1:0] bitmask, lit, opa, alu_res;
   logic alu_c, alu_dc, alu_z;
   rca_pkg::rca_aluop_e alu_op;
   logic use_lit, wr_w, wr_f, fl_c, fl_dc, fl_z, skip_z;
   logic f_we, ram_we, jump, skip, kill, push, pop;

   assign rst = srst || !master_reset_n; // RL13

   // Instruction fields
   assign grp = ir_q[11:10];
   assign bop = ir_q[9:6];
   assign lop = ir_q[9:8];
   assign dst_f = ir_q[5];
   assign bsel = ir_q[7:5];
   assign is_bit = (grp == 2'h1);
   assign is_ctl = (grp == 2'h2);

   // Decode
   always_comb begin
      alu_op = rca_pkg::ALU_PASSB;
      use_lit = 1'b0;
      wr_w = 1'b0;
      wr_f = 1'b0;
      fl_c = 1'b0;
      fl_dc = 1'b0;
      fl_z = 1'b0;
      skip_z = 1'b0;
      unique case (grp)
         2'h0: begin
            wr_w = !dst_f;
            wr_f = dst_f;
            fl_z = 1'b1;
            unique case (bop)
               4'h0: begin
                  alu_op = rca_pkg::ALU_PASSA;
                  wr_w = 1'b0;
                  fl_z = 1'b0;
               end
               4'h1: alu_op = rca_pkg::ALU_CLR;
               4'h2: begin
                  alu_op = rca_pkg::ALU_SUB;
                  fl_c = 1'b1; // RL10
                  fl_dc = 1'b1;
               end
               4'h3: alu_op = rca_pkg::ALU_DEC;
               4'h4: alu_op = rca_pkg::ALU_IOR;
               4'h5: alu_op = rca_pkg::ALU_AND;
               4'h6: alu_op = rca_pkg::ALU_XOR;
               4'h7: begin
                  alu_op = rca_pkg::ALU_ADD;
                  fl_c = 1'b1; // RL10
                  fl_dc = 1'b1;
               end
               4'h8: alu_op = rca_pkg::ALU_PASSB;
               4'h9: alu_op = rca_pkg::ALU_COM;
               4'ha: alu_op = rca_pkg::ALU_INC;
               4'hb: begin
                  alu_op = rca_pkg::ALU_DEC;
                  fl_z = 1'b0;
                  skip_z = 1'b1;
               end
               4'hc: begin
                  alu_op = rca_pkg::ALU_RR;
                  fl_z = 1'b0;
                  fl_c = 1'b1;
               end
               4'hd: begin
                  alu_op = rca_pkg::ALU_RL;
                  fl_z = 1'b0;
                  fl_c = 1'b1;
               end
               4'he: begin
                  alu_op = rca_pkg::ALU_SWAP;
                  fl_z = 1'b0;
               end
               4'hf: begin
                  alu_op = rca_pkg::ALU_INC;
                  fl_z = 1'b0;
                  skip_z = 1'b1;
               end
            endcase
         end
         2'h1: begin
            alu_op = lop[0] ? rca_pkg::ALU_IOR : rca_pkg::ALU_AND;
            use_lit = 1'b1;
            wr_f = !lop[1];
         end
         2'h2: begin
            alu_op = rca_pkg::ALU_PASSA;
            use_lit = 1'b1;
            wr_w = (lop == 2'h0);
         end
         2'h3: begin
            use_lit = 1'b1;
            wr_w = 1'b1;
            fl_z = (lop != 2'h0);
            unique case (lop)
               2'h0: alu_op = rca_pkg::ALU_PASSA;
               2'h1: alu_op = rca_pkg::ALU_IOR;
               2'h2: alu_op = rca_pkg::ALU_AND;
               2'h3: alu_op = rca_pkg::ALU_XOR;
            endcase
         end
      endcase
   end

   // Operands: accumulator or literal against a file register
   assign bitmask = DW'(1) << bsel;
   assign lit = is_bit ? (lop[0] ? bitmask : ~bitmask) : ir_q[7:0];
   assign opa = use_lit ? lit : w_q; // RL8
   assign ram_val = fwd_q ? fwd_data_q : ram_rdata;
   assign file_val = (fa_q == rca_pkg::A_INDF || fa_q == rca_pkg::A_TMR) ? '0 :
                     (fa_q == rca_pkg::A_PCL) ? pc_q[7:0] :
                     (fa_q == rca_pkg::A_STATUS) ? status_q :
                     (fa_q == rca_pkg::A_FSR) ? fsr_q : ram_val; // RL6

   rca_alu #(
      .W(DW)
   ) u_alu (
      .op(alu_op),
      .opa(opa),
      .opb(file_val),
      .cin(status_q[rca_pkg::ST_C]),
      .res(alu_res),
      .cout(alu_c),
      .dcout(alu_dc),
      .zero(alu_z)
   );

   // Execute effects
   assign f_we = ex_v_q && wr_f;
   assign ram_we = f_we && (fa_q >= rca_pkg::A_RAM0);
   assign skip = ex_v_q && ((skip_z && alu_z) || (is_bit && lop[1] && (file_val[bsel] == lop[0])));
   assign jump = (ex_v_q && is_ctl) || (f_we && fa_q == rca_pkg::A_PCL); // RL6
   assign kill = jump || skip; // RL14
   assign push = ex_v_q && is_ctl && (lop == 2'h1);
   assign pop = ex_v_q && is_ctl && (lop == 2'h0);
   assign tgt = !is_ctl ? PC_W'(alu_res) :
                (lop == 2'h0) ? stk0_q :
                (lop == 2'h1) ? PC_W'(ir_q[7:0]) : PC_W'(ir_q[8:0]);

   assign pc_d = rst ? '1 : jump ? tgt : pc_q + PC_W'(1); // RL3
   assign ir_d = rst ? rca_pkg::INSTR_NOP : rom_data; // RL3
   assign ex_v_d = !rst && !kill; // RL4 RL14
   assign stk0_d = rst ? '0 : push ? pc_q : pop ? stk1_q : stk0_q;
   assign stk1_d = rst ? '0 : push ? stk0_q : stk1_q;
   assign w_d = rst ? rca_pkg::W_RST : (ex_v_q && wr_w) ? alu_res : w_q; // RL9
   assign fsr_d = rst ? rca_pkg::FSR_RST : (f_we && fa_q == rca_pkg::A_FSR) ? alu_res : fsr_q;
   assign st_base = (f_we && fa_q == rca_pkg::A_STATUS) ? alu_res : status_q;

   always_comb begin
      status_d = st_base;
      if (ex_v_q && fl_c) begin
         status_d[rca_pkg::ST_C] = alu_c; // RL10
      end
      if (ex_v_q && fl_dc) begin
         status_d[rca_pkg::ST_DC] = alu_dc; // RL10
      end
      if (ex_v_q && fl_z) begin
         status_d[rca_pkg::ST_Z] = alu_z; // RL10
      end
      if (rst) begin
         status_d = rca_pkg::STATUS_RST;
      end
   end

   // Operand address of the prefetched word, with write forwarding
   assign fa_d = eff_addr(rom_data[4:0], fsr_d); // RL6
   assign fwd_d = ram_we && (fa_q == fa_d);

   // Cycle clock pin divider
   assign cyc_d = rst ? '0 : cyc_q + rca_pkg::CYC_CNT_W'(1);
   assign cco_d = !rst && rc_osc_mode && cyc_q[rca_pkg::CYC_CNT_W-1]; // RL12

   rca_mem #(
      .W(IW),
      .DEPTH(1 << PC_W),
      .AW(PC_W)
   ) u_prog (
      .clk_sys(clk_sys),
      .we(load_en),
      .waddr(load_addr),
      .wdata(load_data),
      .raddr(pc_d), // RL1
      .rdata_q(rom_data)
   ); // RL5

   rca_mem #(
      .W(DW),
      .DEPTH(rca_pkg::RAM_DEPTH),
      .AW(AW)
   ) u_data (
      .clk_sys(clk_sys),
      .we(ram_we),
      .waddr(fa_q),
      .wdata(alu_res),
      .raddr(fa_d), // RL2
      .rdata_q(ram_rdata)
   );

   always_ff @(posedge clk_sys) begin
      pc_q <= pc_d;
      ir_q <= ir_d;
      ex_v_q <= ex_v_d;
      stk0_q <= stk0_d;
      stk1_q <= stk1_d;
      w_q <= w_d;
      status_q <= status_d;
      fsr_q <= fsr_d;
      fa_q <= fa_d;
      fwd_q <= fwd_d;
      fwd_data_q <= alu_res;
      cyc_q <= cyc_d;
      cco_q <= cco_d;
   end

   assign fetch_addr = pc_q;
   assign exec_instr = ir_q;
   assign exec_valid = ex_v_q;
   assign acc_out = w_q;
   assign status_out = status_q;
   assign fsr_out = fsr_q;
   assign cycle_clock_out = cco_q;

   a_fetch_step: assert property (@(posedge clk_sys) disable iff (rst) // RL3
      ex_v_q && !kill |=> pc_q == $past(pc_q) + PC_W'(1))
      else $error("Fetch address did not advance");
   a_single_cycle: assert property (@(posedge clk_sys) disable iff (rst) // RL4
      ex_v_q && !kill |=> ex_v_q)
      else $error("Non-branch instruction stalled the pipe");
   a_branch_refill: assert property (@(posedge clk_sys) disable iff (rst) // RL14
      ex_v_q && jump |=> !ex_v_q ##1 ex_v_q && pc_q == $past(pc_q) + PC_W'(1))
      else $error("Branch refill not exactly one cycle");
   a_zero_flag: assert property (@(posedge clk_sys) disable iff (rst) // RL10
      ex_v_q && fl_z |=> status_q[rca_pkg::ST_Z] == ($past(alu_res) == '0))
      else $error("Zero flag wrong");
   a_sub_borrow: assert property (@(posedge clk_sys) disable iff (rst) // RL11
      ex_v_q && alu_op == rca_pkg::ALU_SUB |=> status_q[rca_pkg::ST_C] == ($past(file_val) >= $past(opa)))
      else $error("Borrow flag wrong");
   a_add_result: assert property (@(posedge clk_sys) disable iff (rst) // RL7
      ex_v_q && alu_op == rca_pkg::ALU_ADD && wr_w |=> w_q == $past(opa) + $past(file_val))
      else $error("Add result wrong");
   a_acc_unmapped: assert property (@(posedge clk_sys) disable iff (rst) // RL9
      ex_v_q && wr_f |=> $stable(w_q))
      else $error("File write changed accumulator");
   a_fsr_map: assert property (@(posedge clk_sys) disable iff (rst) // RL6
      f_we && fa_q == rca_pkg::A_FSR |=> fsr_q == $past(alu_res))
      else $error("Pointer register write lost");
   a_pcl_jump: assert property (@(posedge clk_sys) disable iff (rst) // RL6
      f_we && fa_q == rca_pkg::A_PCL |=> pc_q == PC_W'($past(alu_res)))
      else $error("Program counter write not taken");
   a_clk_quarter: assert property (@(posedge clk_sys) disable iff (rst) // RL12
      rc_osc_mode [*4] ##0 (!$past(rst) && !$past(rst, 2) && !$past(rst, 3))
      |-> cycle_clock_out != $past(cycle_clock_out, 2))
      else $error("Cycle clock not a quarter rate");
   a_reset_pc: assert property (@(posedge clk_sys) disable iff (srst) // RL13
      !master_reset_n |=> pc_q == '1 && !ex_v_q && w_q == rca_pkg::W_RST)
      else $error("Master reset not applied");

   c_branch: cover property (@(posedge clk_sys) disable iff (rst) ex_v_q && jump ##2 ex_v_q);
   c_skip: cover property (@(posedge clk_sys) disable iff (rst) skip);
   c_sub_borrow: cover property (@(posedge clk_sys) disable iff (rst)
      ex_v_q && alu_op == rca_pkg::ALU_SUB && !alu_c);
endmodule

// File: hw/rca_pkg.sv
package rca_pkg;
   // Widths
   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   localparam int PC_W_DFLT = 9;
   localparam int RAM_AW = 5;
   localparam int RAM_DEPTH = 32;
   // Data map
   localparam logic [4:0] A_INDF = 5'h00;
   localparam logic [4:0] A_TMR = 5'h01;
   localparam logic [4:0] A_PCL = 5'h02;
   localparam logic [4:0] A_STATUS = 5'h03;
   localparam logic [4:0] A_FSR = 5'h04;
   localparam logic [4:0] A_RAM0 = 5'h05;
   // Status bit positions
   localparam int ST_C = 0;
   localparam int ST_DC = 1;
   localparam int ST_Z = 2;
   // Reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] FSR_RST = 8'h00;
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [11:0] INSTR_NOP = 12'h000;
   // Cycle clock divider
   localparam int CYC_DIV = 4;
   localparam int CYC_CNT_W = $clog2(CYC_DIV);
   // ALU operations
   typedef enum logic [3:0] {
      ALU_ADD = 4'h0,
      ALU_SUB = 4'h1,
      ALU_AND = 4'h2,
      ALU_IOR = 4'h3,
      ALU_XOR = 4'h4,
      ALU_PASSA = 4'h5,
      ALU_PASSB = 4'h6,
      ALU_COM = 4'h7,
      ALU_INC = 4'h8,
      ALU_DEC = 4'h9,
      ALU_RR = 4'ha,
      ALU_RL = 4'hb,
      ALU_SWAP = 4'hc,
      ALU_CLR = 4'hd
   } rca_aluop_e;
endpackage

// File: hw/rca_mem.sv
`timescale 1ns/1ps
module rca_mem #(
   parameter int W = 8,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   // Clock
   input wire logic clk_sys,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Read port, registered data
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata_q
);
   logic [W-1:0] mem_q [DEPTH];

   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
   end
endmodule

// File: hw/rca_alu.sv
`timescale 1ns/1ps
module rca_alu #(
   parameter int W = rca_pkg::DATA_W
) (
   // Operation
   input wire rca_pkg::rca_aluop_e op,
   // Operands and carry in
   input wire logic [W-1:0] opa,
   input wire logic [W-1:0] opb,
   input wire logic cin,
   // Result and flags
   output logic [W-1:0] res,
   output logic cout,
   output logic dcout,
   output logic zero
);
   logic [W-1:0] add_y;
   logic add_ci;
   logic [W:0] sum;
   logic [4:0] nib;

   // One adder serves add, subtract, increment and decrement
   assign add_y = (op == rca_pkg::ALU_SUB) ? ~opa :
                  (op == rca_pkg::ALU_ADD) ? opa :
                  (op == rca_pkg::ALU_DEC) ? '1 : '0;
   assign add_ci = (op == rca_pkg::ALU_SUB) || (op == rca_pkg::ALU_INC);
   assign sum = {1'b0, opb} + {1'b0, add_y} + (W+1)'(add_ci); // RL7
   assign nib = {1'b0, opb[3:0]} + {1'b0, add_y[3:0]} + 5'(add_ci);
   // Subtract adds the inverse, so carries read as no borrow
   assign dcout = nib[4]; // RL11
   assign zero = (res == '0);

   always_comb begin
      res = '0;
      cout = cin;
      unique case (op)
         rca_pkg::ALU_ADD, rca_pkg::ALU_SUB, rca_pkg::ALU_INC, rca_pkg::ALU_DEC: begin
            res = sum[W-1:0];
            cout = sum[W]; // RL11
         end
         rca_pkg::ALU_AND: res = opa & opb;
         rca_pkg::ALU_IOR: res = opa | opb;
         rca_pkg::ALU_XOR: res = opa ^ opb;
         rca_pkg::ALU_PASSA: res = opa;
         rca_pkg::ALU_PASSB: res = opb;
         rca_pkg::ALU_COM: res = ~opb;
         rca_pkg::ALU_RR: {res, cout} = {cin, opb}; // RL7
         rca_pkg::ALU_RL: {cout, res} = {opb, cin};
         rca_pkg::ALU_SWAP: res = {opb[W/2-1:0], opb[W-1:W/2]};
         rca_pkg::ALU_CLR: res = '0;
         default: res = '0;
      endcase
   end
endmodule

// File: testbench/rca_prog_model.sv
`timescale 1ns/1ps
module rca_prog_model #(
   parameter int AW = 9
) (
   // Clock
   input wire logic clk_sys,
   // Control from the bench
   input wire logic go,
   output logic done,
   // Program store load port
   output logic load_en,
   output logic [AW-1:0] load_addr,
   output logic [rca_pkg::INSTR_W-1:0] load_data,
   // Reset pin
   output logic master_reset_n
);
   logic [rca_pkg::INSTR_W-1:0] img [0:(1<<AW)-1];
   logic busy_q;
   logic rel_q = 1'b0;

   initial begin
      done = 1'b0;
      busy_q = 1'b0;
      load_en = 1'b0;
      load_addr = '0;
      load_data = '0;
      master_reset_n = 1'b1;
   end

   // Whole store rewritten while the core is held in reset
   // Reset lifts one edge after the last word lands, so the first fetch sees it
   always @(posedge clk_sys) begin
      done <= 1'b0;
      rel_q <= 1'b0;
      if (go && !busy_q) begin
         busy_q <= 1'b1;
         master_reset_n <= 1'b0;
         load_en <= 1'b1;
         load_addr <= '0;
         load_data <= img[0];
      end else if (rel_q) begin
         master_reset_n <= 1'b1;
         done <= 1'b1;
      end else if (busy_q && load_addr == {AW{1'b1}}) begin
         busy_q <= 1'b0;
         load_en <= 1'b0;
         load_data <= ~load_data;
         rel_q <= 1'b1;
      end else if (busy_q) begin
         load_addr <= load_addr + 1'b1;
         load_data <= img[load_addr + 1'b1];
      end
   end
endmodule

// File: testbench/risc_core_alu_pipeline_tb_top.sv
`timescale 1ns/1ps
module risc_core_alu_pipeline_tb_top;
   localparam int PCW = 9;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic rc_osc_mode = 1'b0;
   logic go = 1'b0;
   logic done, load_en, master_reset_n, cycle_clock_out, exec_valid;
   logic [PCW-1:0] load_addr, fetch_addr;
   logic [11:0] load_data, exec_instr;
   logic [7:0] acc_out, status_out, fsr_out;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   logic hist [0:12];
   logic [PCW-1:0] exp_fa [0:12] = '{9'h1ff, 9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005,
      9'h007, 9'h008, 9'h009, 9'h00a, 9'h009, 9'h00a};
   logic exp_v [0:12] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   logic [7:0] exp_acc [0:12] = '{8'h00, 8'h00, 8'h00, 8'h3c, 8'h3c, 8'h0a, 8'h0a, 8'h0a, 8'h0a,
      8'h3c, 8'h09, 8'h09, 8'h09};
   logic [3:0] ops [0:11] = '{4'h7, 4'h2, 4'h5, 4'h4, 4'h6, 4'h3, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd, 4'he};
   logic [3:0] c_op [0:5] = '{4'h7, 4'h2, 4'h2, 4'h5, 4'h4, 4'h6};
   logic [7:0] c_a [0:5] = '{8'h01, 8'h5a, 8'h01, 8'hf0, 8'h00, 8'ha5};
   logic [7:0] c_b [0:5] = '{8'hff, 8'h5a, 8'h00, 8'h0f, 8'h00, 8'h5a};

   always #5 clk_sys = ~clk_sys;

   rca_prog_model #(.AW(PCW)) prog (
      .clk_sys(clk_sys), .go(go), .done(done), .load_en(load_en), .load_addr(load_addr),
      .load_data(load_data), .master_reset_n(master_reset_n));

   rca_core #(.PC_W(PCW)) dut (
      .clk_sys(clk_sys), .srst(srst), .master_reset_n(master_reset_n), .rc_osc_mode(rc_osc_mode),
      .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .fetch_addr(fetch_addr),
      .exec_instr(exec_instr), .exec_valid(exec_valid), .acc_out(acc_out), .status_out(status_out),
      .fsr_out(fsr_out), .cycle_clock_out(cycle_clock_out));

   task automatic fail(input string msg);
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
   endtask

   task automatic chk_addr(input logic [PCW-1:0] got, input logic [PCW-1:0] exp, input string what);
      n_tests++;
      if (got !== exp) fail($sformatf("%s got %h exp %h", what, got, exp));
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) fail($sformatf("%s got %b exp %b", what, got, exp));
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         fail("run too long");
         summarize();
      end
   end

   task automatic clear_img();
      for (int i = 0; i < (1 << PCW); i++) prog.img[i] = 12'h000;
   endtask

   task automatic run_prog(input logic rc);
      int n;
      @(posedge clk_sys);
      rc_osc_mode <= rc;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (done !== 1'b1 && n < 2000);
      if (n >= 2000) fail("program load stalled");
   endtask

   // Flags and result of f op W, W = a, f = b
   function automatic logic [15:0] alu_exp(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      logic c, dc, z;
      c = 1'b0;
      dc = 1'b0;
      case (op)
         4'h7: begin
            s = {1'b0, b} + {1'b0, a};
            c = s[8];
            dc = ({1'b0, b[3:0]} + {1'b0, a[3:0]}) > 5'h0f;
         end
         4'h2: begin
            s = {1'b0, b - a};
            c = b >= a;
            dc = b[3:0] >= a[3:0];
         end
         4'h5: s = {1'b0, b & a};
         4'h4: s = {1'b0, b | a};
         4'h6: s = {1'b0, b ^ a};
         4'h3: s = {1'b0, b - 8'h01};
         4'h8: s = {1'b0, b};
         4'h9: s = {1'b0, ~b};
         4'ha: s = {1'b0, b + 8'h01};
         4'hc: begin
            s = {2'b00, b[7:1]};
            c = b[0];
         end
         4'hd: begin
            s = {1'b0, b[6:0], 1'b0};
            c = b[7];
         end
         default: s = {1'b0, b[3:0], b[7:4]};
      endcase
      // Rotates and nibble swap leave zero as cleared by reset
      z = (op < 4'hc) && (s[7:0] == 8'h00);
      return {5'h00, z, dc, c, s[7:0]};
   endfunction

   task automatic alu_test(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
      logic [15:0] e;
      clear_img();
      prog.img[0] = {4'hc, b};
      prog.img[1] = 12'h028;
      prog.img[2] = {4'hc, a};
      prog.img[3] = {2'b00, op, 1'b0, 5'h08};
      prog.img[4] = 12'ha04;
      run_prog(1'b0);
      repeat (12) @(negedge clk_sys);
      e = alu_exp(op, a, b);
      chk_byte(acc_out, e[7:0], "accumulator");
      chk_byte(status_out, e[15:8], "status");
      chk_bit(cycle_clock_out, 1'b0, "cycle clock off");
      $display("alu test op %h a %h b %h done", op, a, b);
   endtask

   task automatic pipe_test();
      clear_img();
      prog.img[0] = 12'hc3c;
      prog.img[1] = 12'h02a;
      prog.img[2] = 12'hc0a;
      prog.img[3] = 12'h024;
      prog.img[4] = 12'ha07;
      prog.img[5] = 12'hcee;
      prog.img[7] = 12'h200;
      prog.img[8] = 12'h202;
      prog.img[9] = 12'h022;
      run_prog(1'b1);
      for (int t = 0; t < 13; t++) begin
         if (t > 0) @(negedge clk_sys);
         hist[t] = cycle_clock_out;
         chk_addr(fetch_addr, exp_fa[t], "fetch address");
         chk_bit(exec_valid, exp_v[t], "execute valid");
         chk_byte(acc_out, exp_acc[t], "pipeline accumulator");
         if (t >= 5) chk_bit(cycle_clock_out, hist[t-4], "cycle clock period");
         if (t >= 3) chk_bit(cycle_clock_out, ~hist[t-2], "cycle clock half period");
      end
      chk_byte(fsr_out, 8'h0a, "pointer");
      chk_byte(status_out, 8'h00, "status after moves");
      @(posedge clk_sys);
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(negedge clk_sys);
      chk_addr(fetch_addr, 9'h1ff, "reset vector");
      chk_byte(acc_out, 8'h00, "accumulator in reset");
      chk_bit(exec_valid, 1'b0, "no execute in reset");
      $display("pipeline test done");
   endtask

   initial begin
      void'($urandom(32'hc89d));
      repeat (10) @(posedge clk_sys);
      srst <= 1'b0;
      pipe_test();
      for (int i = 0; i < 30; i++) begin
         if (i < 6) alu_test(c_op[i], c_a[i], c_b[i]);
         else alu_test(ops[$urandom % 12], 8'($urandom), 8'($urandom));
      end
      summarize();
   end
endmodule
